// File: include/mfti_pkg.sv
// Constants and carrier types for the FIFO threshold, PHY address, holdoff and gap register bank.
// Assumes a 32-bit AXI4-Lite slave port with word-aligned registers at four times their word index.
package mfti_pkg;

	// ----------------------------------------------------------------
	// Bus geometry and register indices
	// ----------------------------------------------------------------
	localparam int         MFTI_ADDR_W     = 8;
	localparam int         MFTI_IDX_W      = MFTI_ADDR_W - 2;
	localparam logic [5:0] MFTI_IDX_RX_NF  = 6'h0c;
	localparam logic [5:0] MFTI_IDX_TX_NE  = 6'h0d;
	localparam logic [5:0] MFTI_IDX_TX_NF  = 6'h0e;
	localparam logic [5:0] MFTI_IDX_PHY0   = 6'h0f;
	localparam logic [5:0] MFTI_IDX_PHY1   = 6'h10;
	localparam logic [5:0] MFTI_IDX_QUANTA = 6'h11;
	localparam logic [5:0] MFTI_IDX_RSV_LO = 6'h12;
	localparam logic [5:0] MFTI_IDX_RSV_HI = 6'h16;
	localparam logic [5:0] MFTI_IDX_IPG    = 6'h17;

	// ----------------------------------------------------------------
	// Field widths and positions
	// ----------------------------------------------------------------
	localparam int MFTI_THR_W    = 16;
	localparam int MFTI_PHY_W    = 5;
	localparam int MFTI_QUANTA_W = 16;
	localparam int MFTI_IPG_W    = 5;
	localparam int MFTI_LAT_W    = 4;
	localparam int MFTI_FIELD_LSB = 0;

	// ----------------------------------------------------------------
	// Reset values and fixed values of the reduced variant
	// ----------------------------------------------------------------
	localparam logic [15:0] MFTI_THR_RST      = 16'h0000;
	localparam logic [4:0]  MFTI_PHY_RST      = 5'h00;
	localparam logic [15:0] MFTI_QUANTA_RST   = 16'hffff;
	localparam logic [4:0]  MFTI_IPG_RST      = 5'h00;
	localparam logic [15:0] MFTI_SMALL_RX_NF  = 16'h0008;
	localparam logic [15:0] MFTI_SMALL_TX_NE  = 16'h0008;
	localparam logic [15:0] MFTI_SMALL_TX_NF  = 16'h0003;
	localparam logic [4:0]  MFTI_SMALL_IPG    = 5'h0c;

	// ----------------------------------------------------------------
	// Ready latency and gap limits
	// ----------------------------------------------------------------
	localparam logic [15:0] MFTI_LAT_BASE     = 16'h0003;
	localparam logic [15:0] MFTI_LAT_MAX      = 16'h0008;
	localparam logic [4:0]  MFTI_IPG_MIN      = 5'h08;
	localparam logic [4:0]  MFTI_IPG_MAX      = 5'h1a;
	localparam logic [4:0]  MFTI_IPG_FALLBACK = 5'h0c;

	// ----------------------------------------------------------------
	// Bus response codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MFTI_RESP_OKAY   = 2'h0;
	localparam logic [1:0] MFTI_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [MFTI_ADDR_W-1:0] awaddr;
		logic                   awvalid;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   wvalid;
		logic                   bready;
		logic [MFTI_ADDR_W-1:0] araddr;
		logic                   arvalid;
		logic                   rready;
	} mfti_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} mfti_axil_rsp_t;

	typedef struct packed {
		logic [MFTI_THR_W-1:0]    rx_nearly_full;
		logic [MFTI_THR_W-1:0]    tx_nearly_empty;
		logic [MFTI_THR_W-1:0]    tx_nearly_full;
		logic [MFTI_LAT_W-1:0]    tx_ready_latency;
		logic [MFTI_PHY_W-1:0]    phy_addr0;
		logic [MFTI_PHY_W-1:0]    phy_addr1;
		logic [MFTI_QUANTA_W-1:0] xoff_spacing;
		logic [MFTI_IPG_W-1:0]    ipg_bytes;
	} mfti_cfg_t;

	typedef struct packed {
		mfti_axil_rsp_t           rsp;
		logic                     aw_full;
		logic                     w_full;
		logic [MFTI_IDX_W-1:0]    aw_idx;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic [MFTI_THR_W-1:0]    rx_nf;
		logic [MFTI_THR_W-1:0]    tx_ne;
		logic [MFTI_THR_W-1:0]    tx_nf;
		logic [MFTI_PHY_W-1:0]    phy0;
		logic [MFTI_PHY_W-1:0]    phy1;
		logic [MFTI_QUANTA_W-1:0] quanta;
		logic [MFTI_IPG_W-1:0]    ipg;
		mfti_cfg_t                cfg;
		logic [MFTI_QUANTA_W-1:0] hold_count;
		logic                     xoff_pending;
		logic                     xoff_send;
	} mfti_state_t;

endpackage

// File: logic/mfti_regs.sv
// Register bank for FIFO thresholds, PHY address windows, XOFF holdoff and inter-packet gap.
// Assumes an AXI4-Lite master on aclk and FIFO, management and transmit logic on the same clock.
`timescale 1ns/10ps

module mfti_regs
	import mfti_pkg::*;
#(
	parameter bit SMALL_MAC = 1'b0
) (
	input  wire logic           aclk,             // Register and control clock, 50 MHz.
	input  wire logic           aresetn,          // Synchronous reset, active low.
	input  wire mfti_axil_req_t axil_req,         // AXI4-Lite request channels.
	output mfti_axil_rsp_t      axil_rsp,         // AXI4-Lite answer channels.
	input  wire logic           flow_ctrl_enable, // Flow control enabled, level.
	input  wire logic           xoff_request,     // FIFO asks for an XOFF, one-cycle pulse.
	input  wire logic           quanta_tick,      // One pause quantum elapsed, one-cycle pulse.
	output mfti_cfg_t           cfg,              // Settings in effect for the datapath.
	output logic                xoff_send         // Issue one XOFF frame, one-cycle pulse.
);

	// ----------------------------------------------------------------
	// Reset values, which depend on the variant
	// ----------------------------------------------------------------
	localparam logic [MFTI_THR_W-1:0] RX_NF_RST = SMALL_MAC ? MFTI_SMALL_RX_NF : MFTI_THR_RST;
	localparam logic [MFTI_THR_W-1:0] TX_NE_RST = SMALL_MAC ? MFTI_SMALL_TX_NE : MFTI_THR_RST;
	localparam logic [MFTI_THR_W-1:0] TX_NF_RST = SMALL_MAC ? MFTI_SMALL_TX_NF : MFTI_THR_RST;
	localparam logic [MFTI_IPG_W-1:0] IPG_RST   = SMALL_MAC ? MFTI_SMALL_IPG : MFTI_IPG_RST;

	// ----------------------------------------------------------------
	// State and decode signals
	// ----------------------------------------------------------------
	mfti_state_t           s;
	mfti_state_t           next_s;
	logic [31:0]           old_word;
	logic [31:0]           new_word;
	logic [1:0]            wr_resp;
	logic [MFTI_IDX_W-1:0] rd_idx;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Byte lanes not strobed keep their present contents.
	// Narrow writes let software change one field without reading the word first.
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] wr_val,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wr_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------

	// Word indices outside the bank answer with an error.
	function automatic logic idx_mapped(input logic [MFTI_IDX_W-1:0] idx);
		return (idx >= MFTI_IDX_RX_NF) && (idx <= MFTI_IDX_IPG);
	endfunction

	// Reserved words inside the bank read as zero and swallow writes.
	function automatic logic idx_reserved(input logic [MFTI_IDX_W-1:0] idx);
		return (idx >= MFTI_IDX_RSV_LO) && (idx <= MFTI_IDX_RSV_HI);
	endfunction

	// Response code of an access: reserved and mapped words are OKAY, all others an error.
	function automatic logic [1:0] access_resp(input logic [MFTI_IDX_W-1:0] idx);
		logic [1:0] r;
		if (idx_reserved(idx)) begin
			r = MFTI_RESP_OKAY;
		end else if (idx_mapped(idx)) begin
			r = MFTI_RESP_OKAY;
		end else begin
			r = MFTI_RESP_SLVERR;
		end
		return r;
	endfunction

	// Read value of one word; unused upper bits always come back as zero.
	function automatic logic [31:0] read_word(
		input mfti_state_t           st,
		input logic [MFTI_IDX_W-1:0] idx
	);
		logic [31:0] val;
		val = 32'h0000_0000;
		case (idx)
			MFTI_IDX_RX_NF: begin
				val[MFTI_FIELD_LSB +: MFTI_THR_W] = st.rx_nf;
			end
			MFTI_IDX_TX_NE: begin
				val[MFTI_FIELD_LSB +: MFTI_THR_W] = st.tx_ne;
			end
			MFTI_IDX_TX_NF: begin
				val[MFTI_FIELD_LSB +: MFTI_THR_W] = st.tx_nf;
			end
			MFTI_IDX_PHY0: begin
				val[MFTI_FIELD_LSB +: MFTI_PHY_W] = st.phy0;
			end
			MFTI_IDX_PHY1: begin
				val[MFTI_FIELD_LSB +: MFTI_PHY_W] = st.phy1;
			end
			MFTI_IDX_QUANTA: begin
				val[MFTI_FIELD_LSB +: MFTI_QUANTA_W] = st.quanta;
			end
			MFTI_IDX_IPG: begin
				val[MFTI_FIELD_LSB +: MFTI_IPG_W] = st.ipg;
			end
			default: begin
				val = 32'h0000_0000;
			end
		endcase
		return val;
	endfunction

	// ----------------------------------------------------------------
	// Field encodings toward the datapath
	// ----------------------------------------------------------------

	// Ready latency is the threshold less the base, clamped to the stream's limit.
	// Clamping rather than wrapping keeps an illegal setting from becoming a short latency.
	function automatic logic [MFTI_LAT_W-1:0] ready_latency(input logic [MFTI_THR_W-1:0] thr);
		logic [MFTI_THR_W-1:0] diff;
		logic [MFTI_LAT_W-1:0] lat;
		diff = thr - MFTI_LAT_BASE;
		// Values at or below the base mean no added latency.
		if (thr <= MFTI_LAT_BASE) begin
			lat = '0;
		end else if (diff > MFTI_LAT_MAX) begin
			lat = MFTI_LAT_MAX[MFTI_LAT_W-1:0];
		end else begin
			lat = diff[MFTI_LAT_W-1:0];
		end
		return lat;
	endfunction

	// Gap in effect: the programmed value when legal, else the fallback.
	// Only the datapath sees the fallback; a read of the register returns the raw value.
	function automatic logic [MFTI_IPG_W-1:0] gap_in_effect(input logic [MFTI_IPG_W-1:0] ipg);
		logic [MFTI_IPG_W-1:0] g;
		if ((ipg >= MFTI_IPG_MIN) && (ipg <= MFTI_IPG_MAX)) begin
			g = ipg;
		end else begin
			g = MFTI_IPG_FALLBACK;
		end
		return g;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		// Everything holds by default; each section below changes only the fields it owns.
		next_s   = s;
		rd_idx   = axil_req.araddr[MFTI_ADDR_W-1:2];
		old_word = read_word(s, s.aw_idx);
		new_word = merge_bytes(old_word, s.wdata, s.wstrb);
		wr_resp  = access_resp(s.aw_idx);

		// ----------------------------------------------------------------
		// Write address and data channels
		// ----------------------------------------------------------------
		// Address and data are taken independently and parked until both are in.
		if (s.rsp.awready && axil_req.awvalid) begin
			next_s.aw_full = 1'b1;
			next_s.aw_idx  = axil_req.awaddr[MFTI_ADDR_W-1:2];
		end
		if (s.rsp.wready && axil_req.wvalid) begin
			next_s.w_full = 1'b1;
			next_s.wdata  = axil_req.wdata;
			next_s.wstrb  = axil_req.wstrb;
		end
		if (s.rsp.bvalid && axil_req.bready) begin
			next_s.rsp.bvalid = 1'b0;
		end

		// ----------------------------------------------------------------
		// Write commit
		// ----------------------------------------------------------------
		// Commit a held write and raise its response in the same step.
		// Writes to fixed registers of the reduced variant are answered OKAY and dropped.
		if (s.aw_full && s.w_full && !s.rsp.bvalid) begin
			next_s.aw_full    = 1'b0;
			next_s.w_full     = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp  = wr_resp;
			case (s.aw_idx)
				MFTI_IDX_RX_NF: begin
					if (!SMALL_MAC) begin
						next_s.rx_nf = new_word[MFTI_FIELD_LSB +: MFTI_THR_W];
					end
				end
				MFTI_IDX_TX_NE: begin
					if (!SMALL_MAC) begin
						next_s.tx_ne = new_word[MFTI_FIELD_LSB +: MFTI_THR_W];
					end
				end
				MFTI_IDX_TX_NF: begin
					if (!SMALL_MAC) begin
						next_s.tx_nf = new_word[MFTI_FIELD_LSB +: MFTI_THR_W];
					end
				end
				MFTI_IDX_PHY0: begin
					next_s.phy0 = new_word[MFTI_FIELD_LSB +: MFTI_PHY_W];
				end
				MFTI_IDX_PHY1: begin
					next_s.phy1 = new_word[MFTI_FIELD_LSB +: MFTI_PHY_W];
				end
				MFTI_IDX_QUANTA: begin
					next_s.quanta = new_word[MFTI_FIELD_LSB +: MFTI_QUANTA_W];
				end
				MFTI_IDX_IPG: begin
					if (!SMALL_MAC) begin
						next_s.ipg = new_word[MFTI_FIELD_LSB +: MFTI_IPG_W];
					end
				end
				default: begin
					// Reserved and unmapped words hold every register; only the response differs.
					next_s.rx_nf = s.rx_nf;
				end
			endcase
		end

		// Readiness follows the next state, so a freed slot is offered at the very next edge.
		next_s.rsp.awready = !next_s.aw_full && !next_s.rsp.bvalid;
		next_s.rsp.wready  = !next_s.w_full && !next_s.rsp.bvalid;

		// ----------------------------------------------------------------
		// Read channel
		// ----------------------------------------------------------------
		// Reads answer one cycle after the address is taken.
		// The word comes from the present state, so a write committing at the same edge is not yet seen.
		if (s.rsp.rvalid && axil_req.rready) begin
			next_s.rsp.rvalid = 1'b0;
		end
		if (s.rsp.arready && axil_req.arvalid) begin
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata  = read_word(s, rd_idx);
			next_s.rsp.rresp  = access_resp(rd_idx);
		end
		// Holding arready low while a word waits keeps a single read in flight.
		next_s.rsp.arready = !next_s.rsp.rvalid;

		// ----------------------------------------------------------------
		// XOFF spacing
		// ----------------------------------------------------------------
		// After one XOFF is sent, the next waits until the holdoff counter has run out.
		// Requests during the wait merge into one pending send; a zero spacing sends each at once.
		// Dropping flow control clears both, so re-enabling starts without a stale request.
		next_s.xoff_send = 1'b0;
		if (!flow_ctrl_enable) begin
			next_s.xoff_pending = 1'b0;
			next_s.hold_count   = '0;
		end else if (s.hold_count != '0) begin
			if (quanta_tick) begin
				next_s.hold_count = s.hold_count - 1'b1;
			end
			if (xoff_request) begin
				next_s.xoff_pending = 1'b1;
			end
		end else if (s.xoff_pending || xoff_request) begin
			next_s.xoff_send    = 1'b1;
			next_s.hold_count   = s.quanta;
			// A request in the very cycle a pending one goes out stays pending: the set wins.
			next_s.xoff_pending = s.xoff_pending && xoff_request;
		end

		// ----------------------------------------------------------------
		// Settings in effect
		// ----------------------------------------------------------------
		// They are taken from the next register values, so they change at the commit edge.
		next_s.cfg.rx_nearly_full   = next_s.rx_nf;
		next_s.cfg.tx_nearly_empty  = next_s.tx_ne;
		next_s.cfg.tx_nearly_full   = next_s.tx_nf;
		next_s.cfg.tx_ready_latency = ready_latency(next_s.tx_nf);
		next_s.cfg.phy_addr0        = next_s.phy0;
		next_s.cfg.phy_addr1        = next_s.phy1;
		next_s.cfg.xoff_spacing     = next_s.quanta;
		next_s.cfg.ipg_bytes        = gap_in_effect(next_s.ipg);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Configuration outputs reset to what the registers imply, so the datapath sees no transient.
			s.rsp                  <= '0;
			s.aw_full              <= 1'b0;
			s.w_full               <= 1'b0;
			s.aw_idx               <= '0;
			s.wdata                <= '0;
			s.wstrb                <= '0;
			s.hold_count           <= '0;
			s.xoff_pending         <= 1'b0;
			s.xoff_send            <= 1'b0;
			s.rx_nf                <= RX_NF_RST;
			s.tx_ne                <= TX_NE_RST;
			s.tx_nf                <= TX_NF_RST;
			s.phy0                 <= MFTI_PHY_RST;
			s.phy1                 <= MFTI_PHY_RST;
			s.quanta               <= MFTI_QUANTA_RST;
			s.ipg                  <= IPG_RST;
			s.cfg.rx_nearly_full   <= RX_NF_RST;
			s.cfg.tx_nearly_empty  <= TX_NE_RST;
			s.cfg.tx_nearly_full   <= TX_NF_RST;
			s.cfg.tx_ready_latency <= '0;
			s.cfg.phy_addr0        <= MFTI_PHY_RST;
			s.cfg.phy_addr1        <= MFTI_PHY_RST;
			s.cfg.xoff_spacing     <= MFTI_QUANTA_RST;
			s.cfg.ipg_bytes        <= SMALL_MAC ? MFTI_SMALL_IPG : MFTI_IPG_FALLBACK;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output is a flop of the state register; nothing combinational reaches a pin.
	assign axil_rsp  = s.rsp;
	assign cfg       = s.cfg;
	assign xoff_send = s.xoff_send;

endmodule // mfti_regs

// File: verification/mfti_regs_props.sv
// Concurrent checks for the threshold, PHY address, holdoff and gap register bank.
// Assumes it is bound to every mfti_regs instance and sees only that instance's ports.
`timescale 1ns/10ps

module mfti_regs_props
	import mfti_pkg::*;
#(
	parameter bit SMALL_MAC = 1'b0
) (
	input wire logic           aclk,             // Clock.
	input wire logic           aresetn,          // Synchronous reset, active low.
	input wire mfti_axil_req_t axil_req,         // Bus requests.
	input wire mfti_axil_rsp_t axil_rsp,         // Bus answers.
	input wire logic           flow_ctrl_enable, // Flow control enable.
	input wire logic           xoff_request,     // XOFF request pulse.
	input wire logic           quanta_tick,      // Quantum pulse.
	input wire mfti_cfg_t      cfg,              // Settings in effect.
	input wire logic           xoff_send         // XOFF issue pulse.
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       ar_hs;
	logic [5:0] ar_idx;
	assign ar_hs  = axil_req.arvalid && axil_rsp.arready;
	assign ar_idx = axil_req.araddr[7:2];

	a_latency_map: assert property (
		{12'h000, cfg.tx_ready_latency} == ((cfg.tx_nearly_full <= 16'h0003) ? 16'h0000 :
		(cfg.tx_nearly_full > 16'h000b) ? 16'h0008 : cfg.tx_nearly_full - 16'h0003))
		else $error("ready latency does not follow the threshold");
	a_gap_range: assert property (cfg.ipg_bytes inside {[5'h08:5'h1a]})
		else $error("gap in effect outside 8 to 26");
	a_small_fixed: assert property (SMALL_MAC |-> cfg.rx_nearly_full == 16'h0008 &&
		cfg.tx_nearly_empty == 16'h0008 && cfg.tx_nearly_full == 16'h0003 && cfg.ipg_bytes == 5'h0c)
		else $error("reduced variant settings not fixed");
	a_reserved_zero: assert property (ar_hs && ar_idx inside {[6'h12:6'h16]} |=>
		axil_rsp.rvalid && axil_rsp.rdata == 32'h0 && axil_rsp.rresp == MFTI_RESP_OKAY)
		else $error("reserved word not read as zero");
	a_upper_zero: assert property (ar_hs && ar_idx inside {6'h0f, 6'h10, 6'h17} |=>
		axil_rsp.rdata[31:5] == 27'h0) else $error("unused upper bits not zero");
	a_quanta_upper: assert property (ar_hs && ar_idx == 6'h11 |=> axil_rsp.rdata[31:16] == 16'h0)
		else $error("holdoff upper bits not zero");
	a_xoff_enabled: assert property (xoff_send |-> $past(flow_ctrl_enable))
		else $error("XOFF sent with flow control off");
	a_xoff_spaced: assert property (xoff_send && cfg.xoff_spacing != 16'h0 |=> !xoff_send)
		else $error("XOFF sent twice in a row");
	a_read_answer: assert property (ar_hs |=> axil_rsp.rvalid) else $error("read answer late");
	a_write_answer: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
		axil_rsp.wready |-> ##[1:2] axil_rsp.bvalid) else $error("write answer late");
	a_unmapped_err: assert property (ar_hs && !(ar_idx inside {[6'h0c:6'h17]}) |=>
		axil_rsp.rresp == MFTI_RESP_SLVERR && axil_rsp.rdata == 32'h0) else $error("unmapped read not refused");
endmodule // mfti_regs_props

bind mfti_regs mfti_regs_props #(.SMALL_MAC(SMALL_MAC)) u_props (
	.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.flow_ctrl_enable(flow_ctrl_enable), .xoff_request(xoff_request), .quanta_tick(quanta_tick),
	.cfg(cfg), .xoff_send(xoff_send)
);

// File: verification/mfti_regs_test.sv
// Self-checking bench for the threshold, PHY address, holdoff and gap register bank.
// Assumes mfti_pkg and the checker are compiled first; a full and a reduced instance share one bus.
`timescale 1ns/10ps

module mfti_regs_test
	import mfti_pkg::*;
;
	logic           aclk;
	logic           aresetn;
	logic           flow_ctrl_enable;
	logic           xoff_request;
	logic           quanta_tick;
	mfti_axil_req_t req;
	mfti_axil_rsp_t rsp;
	mfti_axil_rsp_t rsp_s;
	mfti_cfg_t      cfg;
	mfti_cfg_t      cfg_s;
	logic           xsend;
	logic           xsend_s;
	int             mismatches = 0;
	int             comparisons = 0;
	int             cyc = 0;
	int             sends = 0;
	int             sends_s = 0;
	logic [31:0]    rst_f [12] = '{0, 0, 0, 0, 0, 32'hffff, 0, 0, 0, 0, 0, 0};
	logic [31:0]    rst_s [12] = '{8, 8, 3, 0, 0, 32'hffff, 0, 0, 0, 0, 0, 32'h0c};
	logic [31:0]    msk_f [12] = '{32'hffff, 32'hffff, 32'hffff, 32'h1f, 32'h1f, 32'hffff, 0, 0, 0, 0, 0, 32'h1f};
	logic [31:0]    msk_s [12] = '{8, 8, 3, 32'h1f, 32'h1f, 32'hffff, 0, 0, 0, 0, 0, 32'h0c};
	logic [31:0]    ipg_in [4] = '{7, 8, 26, 27};
	logic [31:0]    ipg_ef [4] = '{12, 8, 26, 12};

	mfti_regs dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
		.flow_ctrl_enable(flow_ctrl_enable), .xoff_request(xoff_request), .quanta_tick(quanta_tick),
		.cfg(cfg), .xoff_send(xsend));
	mfti_regs #(.SMALL_MAC(1'b1)) dut_small (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp_s),
		.flow_ctrl_enable(flow_ctrl_enable), .xoff_request(xoff_request), .quanta_tick(quanta_tick),
		.cfg(cfg_s), .xoff_send(xsend_s));

	always #10 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (xsend === 1'b1)
			sends <= sends + 1;
		if (xsend_s === 1'b1)
			sends_s <= sends_s + 1;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge aclk);
		req.awaddr <= {idx, 2'b00};
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
		chk("bresp_small", {30'h0, er}, {30'h0, rsp_s.bresp});
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [31:0] es, input logic [1:0] er);
		@(posedge aclk);
		req.araddr <= {idx, 2'b00};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		chk("rdata", ed, rsp.rdata);
		chk("rdata_small", es, rsp_s.rdata);
		chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
		chk("rresp_small", {30'h0, er}, {30'h0, rsp_s.rresp});
	endtask

	task automatic pulse(input bit tick);
		@(posedge aclk);
		if (tick)
			quanta_tick <= 1'b1;
		else
			xoff_request <= 1'b1;
		@(posedge aclk);
		quanta_tick <= 1'b0;
		xoff_request <= 1'b0;
		// The three extra edges let the send counters settle before they are compared.
		repeat (3) @(posedge aclk);
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		flow_ctrl_enable = 1'b0;
		xoff_request = 1'b0;
		quanta_tick = 1'b0;
		req = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk("ipg_bytes", 32'h0c, {27'h0, cfg.ipg_bytes});
		chk("xoff_spacing", 32'hffff, {16'h0, cfg.xoff_spacing});
		for (int i = 0; i < 12; i++) rd(6'h0c + 6'(i), rst_f[i], rst_s[i], MFTI_RESP_OKAY);
		for (int i = 0; i < 12; i++) wr(6'h0c + 6'(i), 32'hffffffff, 4'hf, MFTI_RESP_OKAY);
		for (int i = 0; i < 12; i++) rd(6'h0c + 6'(i), msk_f[i], msk_s[i], MFTI_RESP_OKAY);
		chk("ipg_bytes", 32'h0c, {27'h0, cfg.ipg_bytes});
		wr(6'h0f, 32'h0000000a, 4'he, MFTI_RESP_OKAY);
		rd(6'h0f, 32'h1f, 32'h1f, MFTI_RESP_OKAY);
		wr(6'h0f, 32'hffffff0a, 4'h1, MFTI_RESP_OKAY);
		rd(6'h0f, 32'h0a, 32'h0a, MFTI_RESP_OKAY);
		chk("phy_addr0", 32'h0a, {27'h0, cfg.phy_addr0});
		wr(6'h0c, 32'h8, 4'hf, MFTI_RESP_OKAY);
		rd(6'h0c, 32'h8, 32'h8, MFTI_RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(6'h17, ipg_in[i], 4'hf, MFTI_RESP_OKAY);
			rd(6'h17, ipg_in[i], 32'h0c, MFTI_RESP_OKAY);
			chk("ipg_bytes", ipg_ef[i], {27'h0, cfg.ipg_bytes});
			chk("ipg_small", 32'h0c, {27'h0, cfg_s.ipg_bytes});
		end
		for (int i = 3; i < 12; i += 4) begin
			wr(6'h0e, 32'(i), 4'hf, MFTI_RESP_OKAY);
			rd(6'h0e, 32'(i), 32'h3, MFTI_RESP_OKAY);
			chk("latency", 32'(i - 3), {28'h0, cfg.tx_ready_latency});
			chk("latency_small", 32'h0, {28'h0, cfg_s.tx_ready_latency});
		end
		wr(6'h20, 32'h12345678, 4'hf, MFTI_RESP_SLVERR);
		rd(6'h20, 32'h0, 32'h0, MFTI_RESP_SLVERR);
		rd(6'h0b, 32'h0, 32'h0, MFTI_RESP_SLVERR);
		wr(6'h11, 32'h3, 4'hf, MFTI_RESP_OKAY);
		rd(6'h11, 32'h3, 32'h3, MFTI_RESP_OKAY);
		flow_ctrl_enable <= 1'b1;
		pulse(1'b0);
		chk("xoff_sends", 32'd1, 32'(sends));
		pulse(1'b0);
		pulse(1'b1);
		pulse(1'b1);
		chk("xoff_sends", 32'd1, 32'(sends));
		pulse(1'b1);
		chk("xoff_sends", 32'd2, 32'(sends));
		flow_ctrl_enable <= 1'b0;
		pulse(1'b0);
		chk("xoff_sends", 32'd2, 32'(sends));
		flow_ctrl_enable <= 1'b1;
		pulse(1'b0);
		chk("xoff_sends", 32'd3, 32'(sends));
		chk("xoff_sends_small", 32'd3, 32'(sends_s));
		print_verdict();
	end
endmodule // mfti_regs_test
